/* File: logic/sps_pkg.sv */
// How it works
// - direct accesses to 0x80..0xff go to register space, below that to data memory
// - bit access only where address ends in 0 or 8; others take whole bytes
// - the page select is eight bits wide, giving 256 selectable pages
// - only pages 0x00, 0x0c and 0x0f reach peripherals; other pages select nothing
// - three entry page stack: active page, middle entry, bottom entry
// - interrupt entry shifts middle to bottom, active to middle, then loads new page
// - interrupt return moves middle to active and bottom to middle
// - an empty bottom entry holds 0x00, which moves into middle on a pop
// - software writes to stack entries never push or pop
// - interrupt entry loads page 0x00, the controller area network interrupt loads 0x0c
// - a preempting interrupt pushes again and overwrites a software-written bottom entry
`default_nettype none
package sps_pkg;

    localparam logic [7:0] SFR_BASE     = 8'h80;
    localparam logic [7:0] PAGE_GENERAL = 8'h00;
    localparam logic [7:0] PAGE_CAN     = 8'h0c;
    localparam logic [7:0] PAGE_AUX     = 8'h0f;
    localparam logic [7:0] ADDR_ACTIVE  = 8'ha7;
    localparam logic [7:0] ADDR_MIDDLE  = 8'h85;
    localparam logic [7:0] ADDR_BOTTOM  = 8'h86;
    localparam logic [7:0] RESET_PAGE   = 8'h00;
    localparam logic [7:0] EMPTY_PAGE   = 8'h00;
    localparam logic [2:0] BIT_ALIGN    = 3'h0;
    localparam logic [7:0] FULL_MASK    = 8'hff;
    localparam logic [7:0] ONE_BIT      = 8'h01;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       bitOp;
        logic [2:0] bitIdx;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sps_req_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       bitOp;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] bitMask;
        logic [7:0] wdata;
    } sps_sfr_t;

    function automatic logic isSfrAddr(input logic [7:0] addr);
        return (addr & SFR_BASE) == SFR_BASE;
    endfunction : isSfrAddr

    function automatic logic isBitAddressable(input logic [7:0] addr);
        return addr[2:0] == BIT_ALIGN;
    endfunction : isBitAddressable

    function automatic logic isPopulated(input logic [7:0] page);
        return page == PAGE_GENERAL || page == PAGE_CAN || page == PAGE_AUX;
    endfunction : isPopulated

    function automatic logic isStackAddr(input logic [7:0] addr);
        return addr == ADDR_ACTIVE || addr == ADDR_MIDDLE || addr == ADDR_BOTTOM;
    endfunction : isStackAddr

endpackage : sps_pkg
`default_nettype wire

/* File: logic/sps_page_stack.sv */
`timescale 1ns/100ps
`default_nettype none
module sps_page_stack
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       push,
    input  wire logic       pushIsCan,
    input  wire logic       pop,
    input  wire logic       wrActive,
    input  wire logic       wrMiddle,
    input  wire logic       wrBottom,
    input  wire logic [7:0] wdata,
    output var  logic [7:0] activeQ,
    output var  logic [7:0] middleQ,
    output var  logic [7:0] bottomQ
);

    // interrupt movement outranks a software write in the same cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            activeQ <= sps_pkg::RESET_PAGE;
            middleQ <= sps_pkg::EMPTY_PAGE;
            bottomQ <= sps_pkg::EMPTY_PAGE;
        end
        else if (push)
        begin
            bottomQ <= middleQ;
            middleQ <= activeQ;
            activeQ <= pushIsCan ? sps_pkg::PAGE_CAN : sps_pkg::PAGE_GENERAL;
        end
        else if (pop)
        begin
            activeQ <= middleQ;
            middleQ <= bottomQ;
            bottomQ <= sps_pkg::EMPTY_PAGE;
        end
        else
        begin
            if (wrActive)
                activeQ <= wdata;
            if (wrMiddle)
                middleQ <= wdata;
            if (wrBottom)
                bottomQ <= wdata;
        end
    end

    a_push_shift: assert property (@(posedge clk) disable iff (sys_rst)
        push |=> middleQ == $past(activeQ) && bottomQ == $past(middleQ))
        else $error("push did not shift the page stack");

    a_push_page: assert property (@(posedge clk) disable iff (sys_rst)
        push |=> activeQ == ($past(pushIsCan) ? 8'h0c : 8'h00))
        else $error("interrupt entry loaded the wrong page");

    a_pop_restore: assert property (@(posedge clk) disable iff (sys_rst)
        pop && !push |=> activeQ == $past(middleQ) && middleQ == $past(bottomQ))
        else $error("return did not restore the page");

    a_pop_empty: assert property (@(posedge clk) disable iff (sys_rst)
        pop && !push ##1 pop && !push |=> middleQ == 8'h00)
        else $error("empty bottom entry did not read as zero");

    a_write_nomove: assert property (@(posedge clk) disable iff (sys_rst)
        (wrMiddle || wrBottom) && !wrActive && !push && !pop |=> activeQ == $past(activeQ))
        else $error("stack entry write moved the active page");

endmodule : sps_page_stack
`default_nettype wire

/* File: logic/sps_sfr_page_ctl.sv */
`timescale 1ns/100ps
`default_nettype none
module sps_sfr_page_ctl
(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire sps_pkg::sps_req_t coreReq,
    input  wire logic             intTake,
    input  wire logic             intIsCan,
    input  wire logic             retiDone,
    input  wire logic [7:0]       sfrRdata,
    output var  sps_pkg::sps_req_t ramReq,
    output var  sps_pkg::sps_sfr_t sfrBus,
    output var  logic             coreRdValid,
    output var  logic [7:0]       coreRdata,
    output var  logic             coreRdBit,
    output var  logic             bitRefused,
    output var  logic [7:0]       activePage,
    output var  logic [7:0]       pageStackMiddle,
    output var  logic [7:0]       pageStackBottom
);

    logic       inSfr;
    logic       isStack;
    logic       bitBad;
    logic       pagedOk;
    logic       byteWr;
    logic [7:0] localData;

    logic       rdPend_q;
    logic       rdLocal_q;
    logic       rdFwd_q;
    logic [2:0] rdBitIdx_q;
    logic [7:0] localData_q;
    logic [7:0] rdByte;

    always_comb
    begin
        inSfr   = coreReq.valid && sps_pkg::isSfrAddr(coreReq.addr);
        isStack = inSfr && sps_pkg::isStackAddr(coreReq.addr);
        bitBad  = inSfr && coreReq.bitOp && !sps_pkg::isBitAddressable(coreReq.addr);
        pagedOk = inSfr && !isStack && !bitBad && sps_pkg::isPopulated(activePage);
        byteWr  = isStack && coreReq.write && !coreReq.bitOp;
    end

    always_comb
    begin
        case (coreReq.addr)
            sps_pkg::ADDR_ACTIVE: localData = activePage;
            sps_pkg::ADDR_MIDDLE: localData = pageStackMiddle;
            sps_pkg::ADDR_BOTTOM: localData = pageStackBottom;
            default:              localData = sps_pkg::EMPTY_PAGE;
        endcase
    end

    // stack entries change on the taking edge so the next access sees the new page
    sps_page_stack u_stack
    (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .push      (intTake),
        .pushIsCan (intIsCan),
        .pop       (retiDone),
        .wrActive  (byteWr && coreReq.addr == sps_pkg::ADDR_ACTIVE),
        .wrMiddle  (byteWr && coreReq.addr == sps_pkg::ADDR_MIDDLE),
        .wrBottom  (byteWr && coreReq.addr == sps_pkg::ADDR_BOTTOM),
        .wdata     (coreReq.wdata),
        .activeQ   (activePage),
        .middleQ   (pageStackMiddle),
        .bottomQ   (pageStackBottom)
    );

    // data memory path
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            ramReq <= '0;
        else if (coreReq.valid && !sps_pkg::isSfrAddr(coreReq.addr))
            ramReq <= coreReq;
        else
            ramReq <= '0;
    end

    // peripheral register path; unpopulated pages see no strobe at all
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            sfrBus <= '0;
        else
        begin
            sfrBus.rd      <= pagedOk && !coreReq.write;
            sfrBus.wr      <= pagedOk && coreReq.write;
            sfrBus.bitOp   <= pagedOk && coreReq.bitOp;
            sfrBus.page    <= activePage;
            sfrBus.addr    <= coreReq.addr;
            sfrBus.bitMask <= coreReq.bitOp ? (sps_pkg::ONE_BIT << coreReq.bitIdx)
                                            : sps_pkg::FULL_MASK;
            sfrBus.wdata   <= coreReq.wdata;
        end
    end

    // refused bit accesses are reported, never performed
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            bitRefused <= 1'b0;
        else
            bitRefused <= bitBad;
    end

    // read return pipeline, first stage
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rdPend_q    <= 1'b0;
            rdLocal_q   <= 1'b0;
            rdFwd_q     <= 1'b0;
            rdBitIdx_q  <= 3'h0;
            localData_q <= 8'h00;
        end
        else
        begin
            rdPend_q    <= inSfr && !coreReq.write && !bitBad;
            rdLocal_q   <= isStack;
            rdFwd_q     <= pagedOk && !coreReq.write;
            rdBitIdx_q  <= coreReq.bitIdx;
            localData_q <= localData;
        end
    end

    // empty pages and holes read as zero; software must not rely on it
    always_comb
    begin
        if (rdLocal_q)
            rdByte = localData_q;
        else if (rdFwd_q)
            rdByte = sfrRdata;
        else
            rdByte = 8'h00;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            coreRdValid <= 1'b0;
            coreRdata   <= 8'h00;
            coreRdBit   <= 1'b0;
        end
        else
        begin
            coreRdValid <= rdPend_q;
            coreRdata   <= rdByte;
            coreRdBit   <= rdByte[rdBitIdx_q];
        end
    end

    a_ram_route: assert property (@(posedge clk) disable iff (sys_rst)
        coreReq.valid && coreReq.addr < 8'h80 |=> ramReq.valid && !sfrBus.rd && !sfrBus.wr)
        else $error("low direct address not routed to data memory");

    a_sfr_route: assert property (@(posedge clk) disable iff (sys_rst)
        coreReq.valid && coreReq.addr >= 8'h80 |=> !ramReq.valid)
        else $error("register address leaked to data memory");

    a_bit_refuse: assert property (@(posedge clk) disable iff (sys_rst)
        coreReq.valid && coreReq.bitOp && coreReq.addr[7] && coreReq.addr[2:0] != 3'h0
        |=> bitRefused && !sfrBus.wr && !sfrBus.rd)
        else $error("bit access to byte-only register not refused");

    a_page_gate: assert property (@(posedge clk) disable iff (sys_rst)
        (sfrBus.rd || sfrBus.wr) |-> sfrBus.page == 8'h00 || sfrBus.page == 8'h0c || sfrBus.page == 8'h0f)
        else $error("strobe issued on an unpopulated page");

    a_stack_read: assert property (@(posedge clk) disable iff (sys_rst)
        coreReq.valid && !coreReq.write && !coreReq.bitOp && coreReq.addr == 8'ha7 && !intTake && !retiDone
        |-> ##2 coreRdValid && coreRdata == $past(activePage, 2))
        else $error("page select read returned the wrong value");

    a_stack_write: assert property (@(posedge clk) disable iff (sys_rst)
        coreReq.valid && coreReq.write && !coreReq.bitOp && coreReq.addr == 8'h86 && !intTake && !retiDone
        |=> pageStackBottom == $past(coreReq.wdata) && !sfrBus.wr)
        else $error("bottom entry write not applied locally");

    a_ram_copy: assert property (@(posedge clk) disable iff (sys_rst)
        coreReq.valid && coreReq.addr < 8'h80
        |=> ramReq.addr == $past(coreReq.addr) && ramReq.wdata == $past(coreReq.wdata))
        else $error("data memory request not copied");

    a_rd_answer: assert property (@(posedge clk) disable iff (sys_rst)
        coreReq.valid && !coreReq.write && coreReq.addr[7] && !(coreReq.bitOp && coreReq.addr[2:0] != 3'h0)
        |-> ##2 coreRdValid)
        else $error("register read got no answer");

    a_refuse_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        coreReq.valid && coreReq.bitOp && coreReq.addr[7] && coreReq.addr[2:0] != 3'h0 |-> ##2 !coreRdValid)
        else $error("refused bit access produced a read answer");

    a_bit_mask: assert property (@(posedge clk) disable iff (sys_rst)
        coreReq.valid && coreReq.bitOp |=> sfrBus.bitMask == (8'h01 << $past(coreReq.bitIdx)))
        else $error("bit access carried the wrong mask");

    a_byte_mask: assert property (@(posedge clk) disable iff (sys_rst)
        coreReq.valid && !coreReq.bitOp |=> sfrBus.bitMask == 8'hff)
        else $error("byte access carried a partial mask");

    a_page_follow: assert property (@(posedge clk) disable iff (sys_rst)
        sfrBus.rd || sfrBus.wr |-> sfrBus.page == $past(activePage))
        else $error("strobe carried a page other than the active one");

    a_fwd_data: assert property (@(posedge clk) disable iff (sys_rst)
        sfrBus.rd |=> coreRdValid && coreRdata == $past(sfrRdata))
        else $error("peripheral read data not returned");

    a_unpop_zero: assert property (@(posedge clk) disable iff (sys_rst)
        coreReq.valid && !coreReq.write && !coreReq.bitOp && coreReq.addr[7]
        && coreReq.addr != 8'ha7 && coreReq.addr != 8'h85 && coreReq.addr != 8'h86
        && activePage != 8'h00 && activePage != 8'h0c && activePage != 8'h0f
        |-> ##2 coreRdata == 8'h00)
        else $error("unpopulated page read did not return zero");

    a_stack_local: assert property (@(posedge clk) disable iff (sys_rst)
        coreReq.valid && (coreReq.addr == 8'ha7 || coreReq.addr == 8'h85 || coreReq.addr == 8'h86)
        |=> !sfrBus.rd && !sfrBus.wr)
        else $error("page stack access reached the peripheral bus");

    a_middle_read: assert property (@(posedge clk) disable iff (sys_rst)
        coreReq.valid && !coreReq.write && !coreReq.bitOp && coreReq.addr == 8'h85
        |-> ##2 coreRdValid && coreRdata == $past(pageStackMiddle, 2))
        else $error("middle entry read returned the wrong value");

endmodule : sps_sfr_page_ctl
`default_nettype wire

/* File: sim/sps_periph_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sps_periph_model
(
    input  wire logic              clk,
    input  wire sps_pkg::sps_sfr_t sfrBus,
    output var  logic [7:0]        sfrRdata
);
    logic [7:0] lastQ;

    always_ff @(posedge clk)
    begin
        lastQ <= sfrRdata;
    end

    // data depends on page and address only, so the core side can predict it
    // outside a read the bus shows the inverse of the last value, never a stale copy
    always_comb
    begin
        sfrRdata = sfrBus.rd ? (sfrBus.addr ^ sfrBus.page ^ 8'h5a) : ~lastQ;
    end
endmodule : sps_periph_model
`default_nettype wire

/* File: sim/test_sfr_page_stack.sv */
`timescale 1ns/100ps
`default_nettype none
module test_sfr_page_stack;
    logic              clk      = 1'b0;
    logic              sys_rst  = 1'b1;
    sps_pkg::sps_req_t coreReq  = '0;
    logic              intTake  = 1'b0;
    logic              intIsCan = 1'b0;
    logic              retiDone = 1'b0;
    logic [7:0]        sfrRdata;
    sps_pkg::sps_req_t ramReq;
    sps_pkg::sps_sfr_t sfrBus;
    logic              coreRdValid;
    logic [7:0]        coreRdata;
    logic              coreRdBit;
    logic              bitRefused;
    logic [7:0]        activePage;
    logic [7:0]        pageStackMiddle;
    logic [7:0]        pageStackBottom;
    logic [10:0]       expQ[$];
    logic [10:0]       expNote;
    logic [7:0]        expPage  = 8'h00;
    logic [7:0]        pages[5] = '{8'h00, 8'h0c, 8'h0f, 8'h33, 8'hff};
    int                nMismatch   = 0;
    int                totalChecks = 0;
    integer            seed        = 32'h2fc8;
    logic [31:0]       r;
    logic [7:0]        pg;

    always #25 clk = ~clk;

    sps_sfr_page_ctl uut (.clk(clk), .sys_rst(sys_rst), .coreReq(coreReq), .intTake(intTake),
        .intIsCan(intIsCan), .retiDone(retiDone), .sfrRdata(sfrRdata), .ramReq(ramReq), .sfrBus(sfrBus),
        .coreRdValid(coreRdValid), .coreRdata(coreRdata), .coreRdBit(coreRdBit), .bitRefused(bitRefused),
        .activePage(activePage), .pageStackMiddle(pageStackMiddle), .pageStackBottom(pageStackBottom));

    sps_periph_model partner (.clk(clk), .sfrBus(sfrBus), .sfrRdata(sfrRdata));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic endOfTest;
        $display("checks %0d, mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : endOfTest

    task automatic access(input logic wr, input logic bo, input logic [2:0] idx, input logic [7:0] a,
                          input logic [7:0] d);
        @(negedge clk);
        coreReq <= '{1'b1, wr, bo, idx, a, d};
        @(negedge clk);
        coreReq <= '0;
    endtask : access

    // page select write, then a check that the active page took it
    task automatic setPage(input logic [7:0] p);
        access(1'b1, 1'b0, 3'h0, 8'ha7, p);
        expPage = p;
        check(activePage, p);
    endtask : setPage

    // the note carries the bit index so the single-bit answer is checked as well
    task automatic rdExp(input logic bo, input logic [2:0] idx, input logic [7:0] a, input logic [7:0] e,
                         input logic fwd);
        expQ.push_back({idx, e});
        access(1'b0, bo, idx, a, 8'h00);
        check({7'h0, sfrBus.rd}, {7'h0, fwd});
    endtask : rdExp

    task automatic rd(input logic [7:0] a);
        logic pop;
        pop = expPage == 8'h00 || expPage == 8'h0c || expPage == 8'h0f;
        rdExp(1'b0, 3'h0, a, pop ? (a ^ expPage ^ 8'h5a) : 8'h00, pop);
    endtask : rd

    task automatic stackEvt(input logic push, input logic can, input logic [7:0] ea, input logic [7:0] em,
                            input logic [7:0] eb);
        @(negedge clk);
        intTake  <= push;
        intIsCan <= can;
        retiDone <= !push;
        @(negedge clk);
        intTake  <= 1'b0;
        intIsCan <= 1'b0;
        retiDone <= 1'b0;
        expPage = ea;
        check(activePage, ea);
        check(pageStackMiddle, em);
        check(pageStackBottom, eb);
    endtask : stackEvt

    // scoreboard side: every read answer takes the oldest prediction
    always @(negedge clk)
    begin
        if (coreRdValid === 1'b1)
        begin
            if (expQ.size() == 0)
                check({7'h0, coreRdValid}, 8'h00);
            else
            begin
                expNote = expQ.pop_front();
                check(coreRdata, expNote[7:0]);
                check({7'h0, coreRdBit}, {7'h0, expNote[expNote[10:8]]});
            end
        end
    end

    initial
    begin
        for (int i = 0; i < 4000; i++)
            @(posedge clk);
        nMismatch++;
        $display("ERROR %0t: run did not finish", $time);
        endOfTest();
    end

    initial
    begin
        repeat (5) @(negedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        check(pageStackBottom, 8'h00);
        access(1'b1, 1'b0, 3'h0, 8'h7f, 8'h3c);
        check(ramReq.addr, 8'h7f);
        check({7'h0, sfrBus.wr}, 8'h00);
        access(1'b1, 1'b0, 3'h0, 8'h80, 8'h11);
        check({7'h0, sfrBus.wr}, 8'h01);
        check({7'h0, ramReq.valid}, 8'h00);
        rd(8'h90);
        access(1'b0, 1'b1, 3'h2, 8'h91, 8'h00);
        check({7'h0, bitRefused}, 8'h01);
        access(1'b1, 1'b1, 3'h5, 8'h98, 8'hff);
        check(sfrBus.bitMask, 8'h20);
        check({7'h0, bitRefused}, 8'h00);
        rdExp(1'b1, 3'h4, 8'hc8, 8'hc8 ^ 8'h5a, 1'b1);
        $display("decode test done");
        foreach (pages[i])
        begin
            pg = pages[i];
            setPage(pg);
            rd(8'hc4);
            rdExp(1'b0, 3'h0, 8'ha7, pg, 1'b0);
        end
        $display("paging test done");
        setPage(8'h0f);
        access(1'b1, 1'b0, 3'h0, 8'h85, 8'h21);
        access(1'b1, 1'b0, 3'h0, 8'h86, 8'h42);
        check(activePage, 8'h0f);
        check(pageStackMiddle, 8'h21);
        check(pageStackBottom, 8'h42);
        rdExp(1'b0, 3'h0, 8'ha7, 8'h0f, 1'b0);
        rdExp(1'b0, 3'h0, 8'h85, 8'h21, 1'b0);
        rdExp(1'b0, 3'h0, 8'h86, 8'h42, 1'b0);
        stackEvt(1'b1, 1'b1, 8'h0c, 8'h0f, 8'h21);
        access(1'b1, 1'b0, 3'h0, 8'h86, 8'h77);
        stackEvt(1'b1, 1'b0, 8'h00, 8'h0c, 8'h0f);
        rd(8'hc4);
        stackEvt(1'b0, 1'b0, 8'h0c, 8'h0f, 8'h00);
        stackEvt(1'b0, 1'b0, 8'h0f, 8'h00, 8'h00);
        stackEvt(1'b1, 1'b1, 8'h0c, 8'h0f, 8'h00);
        access(1'b1, 1'b0, 3'h0, 8'h86, 8'h55);
        // two returns on back to back edges: the second must see the emptied bottom
        @(negedge clk);
        retiDone <= 1'b1;
        repeat (2) @(negedge clk);
        retiDone <= 1'b0;
        expPage = 8'h55;
        check(activePage, 8'h55);
        check(pageStackMiddle, 8'h00);
        check(pageStackBottom, 8'h00);
        $display("stack test done");
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            pg = r[9:8] == 2'h3 ? r[7:0] : (r[9:8] == 2'h0 ? 8'h00 : (r[9:8] == 2'h1 ? 8'h0c : 8'h0f));
            setPage(pg);
            rd({2'h3, r[21:16]});
        end
        for (int i = 0; i < 10 && expQ.size() != 0; i++)
            @(negedge clk);
        check(8'(expQ.size()), 8'h00);
        $display("random test done");
        endOfTest();
    end
endmodule : test_sfr_page_stack
`default_nettype wire
